// >>> sfc_credit_regs.sv
// Switch credit configuration registers with staged counts and display refresh classifier
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps
// ==================================================
module sfc_credit_regs (
    // Clock, resets and core-count strap
    input  wire logic                          mclk_in,
    input  wire logic                          rst_n_in,
    input  wire logic                          warm_rst_in,
    input  wire logic                          dual_core_in,
    // AXI4-Lite write address and data
    input  wire logic                          s_axi_awvalid_in,
    output logic                               s_axi_awready_out,
    input  wire logic [7:0]                    s_axi_awaddr_in,
    input  wire logic                          s_axi_wvalid_in,
    output logic                               s_axi_wready_out,
    input  wire logic [31:0]                   s_axi_wdata_in,
    input  wire logic [3:0]                    s_axi_wstrb_in,
    // AXI4-Lite write response
    output logic                               s_axi_bvalid_out,
    input  wire logic                          s_axi_bready_in,
    output logic [1:0]                         s_axi_bresp_out,
    // AXI4-Lite read
    input  wire logic                          s_axi_arvalid_in,
    output logic                               s_axi_arready_out,
    input  wire logic [7:0]                    s_axi_araddr_in,
    output logic                               s_axi_rvalid_out,
    input  wire logic                          s_axi_rready_in,
    output logic [31:0]                        s_axi_rdata_out,
    output logic [1:0]                         s_axi_rresp_out,
    // Active credit words
    output logic [31:0]                        act_ri2sw_out,
    output logic [31:0]                        act_sw2ri_out,
    output logic [31:0]                        act_mc2sw_out,
    output logic [31:0]                        act_pool_out,
    output logic [sfc_pkg::RI_DISP_W-1:0]      act_up_disp_out,
    output logic [sfc_pkg::SW_DISP_W-1:0]      act_down_disp_out,
    // Incoming read request header
    input  wire logic                          hdr_valid_in,
    input  wire logic                          hdr_read_in,
    input  wire logic                          hdr_isoc_in,
    input  wire logic                          hdr_passpw_in,
    input  wire logic                          hdr_rsppasspw_in,
    input  wire logic                          hdr_coherent_in,
    input  wire logic [3:0]                    hdr_seqid_in,
    // Classification result
    output logic                               req_valid_out,
    output logic                               high_prio_out,
    output logic                               disp_path_out
);
    import sfc_pkg::*;

    // ==================================================
    // Register storage
    logic [31:0] prog_ri2sw;
    logic [31:0] prog_sw2ri;
    logic [31:0] prog_mc2sw;
    logic [31:0] prog_pool;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        aw_held;
    logic        w_held;
    logic        do_write;
    logic        wr_hit;
    logic        rd_hit;
    logic [31:0] rd_word;
    logic [3:0]  pool_cmd_rst;
    logic [2:0]  dual_sync;
    logic        dual_core;

    // Byte-lane merge limited to writable bits
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb, input logic [31:0] msk);
        logic [31:0] lanes;
        lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & msk;
        return (old & ~lanes) | (nw & lanes);
    endfunction : merge

    // ==================================================
    // Core-count strap: three flops, a change counts once the last two agree
    // Shift stages carry no reset so the strap is sampled while cold reset is held
    always_ff @(posedge mclk_in) begin
        dual_sync <= {dual_sync[1:0], dual_core_in};
    end

    // Filtered strap; a single-cycle glitch never reaches the reset values
    always_ff @(posedge mclk_in) begin
        if (dual_sync[2] == dual_sync[1]) begin
            dual_core <= dual_sync[2];
        end
    end

    // ==================================================
    // Write channel capture, address and data in either order
    assign do_write = aw_held && w_held && !s_axi_bvalid_out;
    assign wr_hit   = (aw_addr == OFS_RI2SW) || (aw_addr == OFS_SW2RI) ||
                      (aw_addr == OFS_MC2SW) || (aw_addr == OFS_POOL);
    assign pool_cmd_rst = dual_core ? RST_POOL_CMD2 : RST_POOL_CMD1;

    // Address latch
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            aw_held           <= 1'b0;
            aw_addr           <= 8'h00;
            s_axi_awready_out <= 1'b1;
        end else if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held           <= 1'b1;
            aw_addr           <= {s_axi_awaddr_in[7:2], 2'b00};
            s_axi_awready_out <= 1'b0;
        end else if (do_write) begin
            aw_held           <= 1'b0;
        end else if (!aw_held && !s_axi_bvalid_out) begin
            s_axi_awready_out <= 1'b1;
        end
    end

    // Data latch
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            w_held           <= 1'b0;
            w_data           <= 32'h0000_0000;
            w_strb           <= 4'h0;
            s_axi_wready_out <= 1'b1;
        end else if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held           <= 1'b1;
            w_data           <= s_axi_wdata_in;
            w_strb           <= s_axi_wstrb_in;
            s_axi_wready_out <= 1'b0;
        end else if (do_write) begin
            w_held           <= 1'b0;
        end else if (!w_held && !s_axi_bvalid_out) begin
            s_axi_wready_out <= 1'b1;
        end
    end

    // Write response, unmapped offsets answer with an error
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    // ==================================================
    // Programmed counts; warm reset leaves them, cold reset restores defaults
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            prog_ri2sw <= RST_RI2SW;
            prog_sw2ri <= RST_SW2RI;
            prog_mc2sw <= RST_MC2SW;
            prog_pool  <= RST_POOL | {28'h000_0000, pool_cmd_rst};
        end else if (do_write) begin
            case (aw_addr)
                OFS_RI2SW: prog_ri2sw <= merge(prog_ri2sw, w_data, w_strb, MSK_RI2SW);
                OFS_SW2RI: prog_sw2ri <= merge(prog_sw2ri, w_data, w_strb, MSK_SW2RI);
                OFS_MC2SW: prog_mc2sw <= merge(prog_mc2sw, w_data, w_strb, MSK_MC2SW);
                OFS_POOL:  prog_pool  <= merge(prog_pool, w_data, w_strb, MSK_POOL);
                default:   prog_pool  <= prog_pool;
            endcase
        end
    end

    // ==================================================
    // Read channel, one word in flight; returns programmed, not active, counts
    always_comb begin
        rd_hit  = 1'b1;
        case ({s_axi_araddr_in[7:2], 2'b00})
            OFS_RI2SW: rd_word = prog_ri2sw;
            OFS_SW2RI: rd_word = prog_sw2ri;
            OFS_MC2SW: rd_word = prog_mc2sw;
            OFS_POOL:  rd_word = prog_pool;
            default: begin
                rd_word = 32'h0000_0000;
                rd_hit  = 1'b0;
            end
        endcase
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0000_0000;
            s_axi_rresp_out   <= RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rdata_out   <= rd_word;
            s_axi_rresp_out   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out  <= 1'b0;
            s_axi_arready_out <= 1'b1;
        end
    end

    // ==================================================
    // Active copies: loaded only at reset, so traffic never sees a half-written allocation
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            act_ri2sw_out <= RST_RI2SW;
            act_sw2ri_out <= RST_SW2RI;
            act_mc2sw_out <= RST_MC2SW;
            act_pool_out  <= RST_POOL | {28'h000_0000, pool_cmd_rst};
        end else if (warm_rst_in) begin
            act_ri2sw_out <= prog_ri2sw;
            act_sw2ri_out <= prog_sw2ri;
            act_mc2sw_out <= prog_mc2sw;
            act_pool_out  <= prog_pool;
        end
    end

    // Per-direction display refresh allocations
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            act_up_disp_out   <= RST_RI2SW[RI_DISP_LSB +: RI_DISP_W];
            act_down_disp_out <= RST_SW2RI[SW_DISP_LSB +: SW_DISP_W];
        end else if (warm_rst_in) begin
            act_up_disp_out   <= prog_ri2sw[RI_DISP_LSB +: RI_DISP_W];
            act_down_disp_out <= prog_sw2ri[SW_DISP_LSB +: SW_DISP_W];
        end
    end

    // ==================================================
    // Display refresh classification, one cycle after the header
    logic is_disp;
    assign is_disp = hdr_read_in && hdr_isoc_in && hdr_passpw_in && hdr_rsppasspw_in &&
                     !hdr_coherent_in && (hdr_seqid_in == 4'h0);

    // Priority and path select travel with the request
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            req_valid_out <= 1'b0;
            high_prio_out <= 1'b0;
            disp_path_out <= 1'b0;
        end else begin
            req_valid_out <= hdr_valid_in;
            high_prio_out <= hdr_valid_in && is_disp;
            disp_path_out <= hdr_valid_in && is_disp;
        end
    end

    // ==================================================
    // Checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    warm_load_a: assert property (warm_rst_in |=> act_sw2ri_out == $past(prog_sw2ri))
        else $error("active word not loaded at warm reset");
    hold_active_a: assert property (!warm_rst_in |=> $stable(act_ri2sw_out))
        else $error("active word changed without warm reset");
    probe_field_a: assert property (warm_rst_in |=>
        act_sw2ri_out[SW_PROBE_LSB +: SW_PROBE_W] == $past(prog_sw2ri[SW_PROBE_LSB +: SW_PROBE_W]))
        else $error("probe count misplaced");
    disp_class_a: assert property (hdr_valid_in && is_disp |=> high_prio_out && disp_path_out)
        else $error("display refresh not prioritised");
    coherent_excl_a: assert property (hdr_coherent_in |=> !high_prio_out)
        else $error("coherent request classed as display refresh");
    seqid_excl_a: assert property (hdr_seqid_in != 4'h0 |=> !disp_path_out)
        else $error("sequenced request classed as display refresh");
    read_back_a: assert property (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == OFS_SW2RI
        |=> s_axi_rvalid_out && s_axi_rdata_out == $past(prog_sw2ri))
        else $error("read does not return programmed word");
    reserved_zero_a: assert property ((prog_ri2sw & ~MSK_RI2SW) == 32'h0 &&
        (prog_sw2ri & ~MSK_SW2RI) == 32'h0 && (prog_mc2sw & ~MSK_MC2SW) == 32'h0)
        else $error("reserved bit set");
    pool_mask_a: assert property ((prog_pool & ~MSK_POOL) == 32'h0)
        else $error("pool reserved bit set");
    write_resp_a: assert property (do_write ##1 s_axi_bvalid_out |-> s_axi_bresp_out ==
        ($past(wr_hit) ? RESP_OKAY : RESP_SLVERR))
        else $error("wrong write response");

    // Every word reaches its active copy at warm reset, never between
    ri_load_a: assert property (warm_rst_in |=> act_ri2sw_out == $past(prog_ri2sw))
        else $error("request-to-switch word not loaded at warm reset");
    mc_load_a: assert property (warm_rst_in |=> act_mc2sw_out == $past(prog_mc2sw))
        else $error("memory word not loaded at warm reset");
    pool_load_a: assert property (warm_rst_in |=> act_pool_out == $past(prog_pool))
        else $error("pool word not loaded at warm reset");
    hold_others_a: assert property (!warm_rst_in |=>
        $stable(act_sw2ri_out) && $stable(act_mc2sw_out) && $stable(act_pool_out))
        else $error("active word changed without warm reset");
    up_disp_a: assert property (warm_rst_in |=>
        act_up_disp_out == $past(prog_ri2sw[RI_DISP_LSB +: RI_DISP_W]))
        else $error("upstream refresh count not loaded");
    down_disp_a: assert property (warm_rst_in |=>
        act_down_disp_out == $past(prog_sw2ri[SW_DISP_LSB +: SW_DISP_W]))
        else $error("downstream refresh count not loaded");
    hold_disp_a: assert property (!warm_rst_in |=> $stable(act_up_disp_out) && $stable(act_down_disp_out))
        else $error("refresh count changed without warm reset");
    warm_keep_a: assert property (warm_rst_in && !do_write |=> $stable(prog_sw2ri) && $stable(prog_pool))
        else $error("warm reset disturbed a programmed word");

    // Classifier answers exactly one cycle after each header
    idle_quiet_a: assert property (!hdr_valid_in |=> !high_prio_out && !disp_path_out)
        else $error("priority raised without a request");
    req_follow_a: assert property (1'b1 |=> req_valid_out == $past(hdr_valid_in))
        else $error("request valid not delayed by one cycle");

    // ==================================================
    // Bus handshake checks: answers stand until taken, one transfer of each kind at a time
    bvalid_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
        s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write answer dropped before taken");
    rvalid_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
        s_axi_rvalid_out && $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out))
        else $error("read answer dropped before taken");
    write_busy_a: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
        else $error("new write taken while answer pending");
    read_busy_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
        else $error("new read taken while answer pending");
    write_lat_a: assert property (aw_held && w_held && !s_axi_bvalid_out |=> s_axi_bvalid_out && !aw_held)
        else $error("write answer late");

    write_c: cover property (do_write && wr_hit);
    warm_c: cover property (do_write ##[1:20] warm_rst_in);
    disp_c: cover property (hdr_valid_in && is_disp);
    unmapped_c: cover property (s_axi_rvalid_out && s_axi_rresp_out == RESP_SLVERR);
    strobe_c: cover property (do_write && wr_hit && w_strb != 4'hF);
endmodule : sfc_credit_regs

// >>> sfc_pkg.sv
// Package: register map, field layout and reset values of the switch credit block
package sfc_pkg;
    // ==================================================
    // Register offsets (byte addresses)
    localparam logic [7:0]  OFS_RI2SW     = 8'h70;
    localparam logic [7:0]  OFS_SW2RI     = 8'h74;
    localparam logic [7:0]  OFS_MC2SW     = 8'h78;
    localparam logic [7:0]  OFS_POOL      = 8'h7C;
    // ==================================================
    // Reset values
    localparam logic [31:0] RST_RI2SW     = 32'h5102_0111;
    localparam logic [31:0] RST_SW2RI     = 32'h5000_8011;
    localparam logic [31:0] RST_MC2SW     = 32'h0800_3800;
    localparam logic [31:0] RST_POOL      = 32'h0000_2210;
    localparam logic [3:0]  RST_POOL_CMD1 = 4'hB;
    localparam logic [3:0]  RST_POOL_CMD2 = 4'hA;
    // ==================================================
    // Writable bit masks, reserved bits stay zero
    localparam logic [31:0] MSK_RI2SW     = 32'hF333_0333;
    localparam logic [31:0] MSK_SW2RI     = 32'hF070_F077;
    localparam logic [31:0] MSK_MC2SW     = 32'h0F00_7F00;
    localparam logic [31:0] MSK_POOL      = 32'h0000_373F;
    // ==================================================
    // Field positions used by the flow-control outputs
    localparam int          RI_DISP_LSB   = 20;
    localparam int          RI_DISP_W     = 2;
    localparam int          SW_DISP_LSB   = 20;
    localparam int          SW_DISP_W     = 3;
    localparam int          SW_PROBE_LSB  = 12;
    localparam int          SW_PROBE_W    = 4;
    localparam int          POOL_CMD_LSB  = 0;
    localparam int          POOL_CMD_W    = 4;
    // ==================================================
    // Bus answers
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;
endpackage : sfc_pkg

// >>> switch_flow_control_credits_tb.sv
// Self-checking testbench for the switch credit configuration registers
`timescale 1ns/100ps
module switch_flow_control_credits_tb;
    import sfc_pkg::*;
    // ==================================================
    // Design signals
    logic        mclk_in, rst_n_in, warm_rst_in, dual_core_in;
    logic        s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
    logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
    logic [3:0]  s_axi_wstrb_in, hdr_seqid_in;
    logic        s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
    logic        s_axi_rvalid_out, s_axi_rready_in;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, act_up_disp_out;
    logic [31:0] act_ri2sw_out, act_sw2ri_out, act_mc2sw_out, act_pool_out;
    logic [2:0]  act_down_disp_out;
    logic        hdr_valid_in, hdr_read_in, hdr_isoc_in, hdr_passpw_in, hdr_rsppasspw_in, hdr_coherent_in;
    logic        req_valid_out, high_prio_out, disp_path_out;
    // ==================================================
    // Bench state; writable masks follow the field layout of each word
    int          n_errors = 0;
    int          samples_checked = 0;
    logic [7:0]  ofs_tbl [4] = '{OFS_RI2SW, OFS_SW2RI, OFS_MC2SW, OFS_POOL};
    logic [31:0] msk_tbl [4] = '{32'hF333_0333, 32'hF070_F077, 32'h0F00_7F00, 32'h0000_373F};
    // Staged words per pass; each switch-to-request raise is paid for from the pool command count
    logic [31:0] wr_tbl [2][4] = '{'{32'hFFFF_FFFF, 32'h5F9F_8F99, 32'hFFFF_FFFF, 32'hFFFF_FFFA},
                                   '{32'h5555_5555, 32'h6020_8012, 32'h5555_5555, 32'h0000_1217}};
    logic [31:0] exp_prog [4];
    logic [31:0] exp_act [4];

    sfc_credit_regs u_sfc_credit_regs (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .warm_rst_in(warm_rst_in), .dual_core_in(dual_core_in),
        .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
        .s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
        .s_axi_wdata_in(s_axi_wdata_in), .s_axi_wstrb_in(s_axi_wstrb_in), .s_axi_bvalid_out(s_axi_bvalid_out),
        .s_axi_bready_in(s_axi_bready_in), .s_axi_bresp_out(s_axi_bresp_out), .s_axi_arvalid_in(s_axi_arvalid_in),
        .s_axi_arready_out(s_axi_arready_out), .s_axi_araddr_in(s_axi_araddr_in),
        .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
        .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
        .act_ri2sw_out(act_ri2sw_out), .act_sw2ri_out(act_sw2ri_out), .act_mc2sw_out(act_mc2sw_out),
        .act_pool_out(act_pool_out), .act_up_disp_out(act_up_disp_out), .act_down_disp_out(act_down_disp_out),
        .hdr_valid_in(hdr_valid_in), .hdr_read_in(hdr_read_in), .hdr_isoc_in(hdr_isoc_in),
        .hdr_passpw_in(hdr_passpw_in), .hdr_rsppasspw_in(hdr_rsppasspw_in), .hdr_coherent_in(hdr_coherent_in),
        .hdr_seqid_in(hdr_seqid_in), .req_valid_out(req_valid_out), .high_prio_out(high_prio_out),
        .disp_path_out(disp_path_out)
    );
    // ==================================================
    // Compare tasks and closing
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word
    task automatic chk_bit(input string nm, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    // ==================================================
    // Bus master; the leading edge keeps a release and a new request in separate steps
    // Waits for the answer however long it takes; only the watchdog ends a hang
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge mclk_in);
        s_axi_awaddr_in  <= a;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wdata_in   <= d;
        s_axi_wvalid_in  <= 1'b1;
        s_axi_bready_in  <= 1'b1;
        do begin
            @(posedge mclk_in);
            if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        end while (!(s_axi_bvalid_out && s_axi_bready_in));
        r = s_axi_bresp_out;
        s_axi_bready_in <= 1'b0;
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk_in);
        s_axi_araddr_in  <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in  <= 1'b1;
        do begin
            @(posedge mclk_in);
            if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
        end while (!(s_axi_rvalid_out && s_axi_rready_in));
        d = s_axi_rdata_out;
        r = s_axi_rresp_out;
        s_axi_rready_in <= 1'b0;
    endtask : axi_read
    // ==================================================
    // Scenarios
    task automatic cold_reset(input logic dual);
        @(posedge mclk_in);
        rst_n_in     <= 1'b0;
        dual_core_in <= dual;
        repeat (20) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        exp_prog = '{32'h5102_0111, 32'h5000_8011, 32'h0800_3800, {28'h0000_221, dual ? 4'hA : 4'hB}};
        exp_act  = exp_prog;
    endtask : cold_reset
    task automatic check_state();
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 4; i++) begin
            axi_read(ofs_tbl[i], d, r);
            chk_word($sformatf("word at %h", ofs_tbl[i]), exp_prog[i], d);
            chk_word("read answer", {30'h0, RESP_OKAY}, {30'h0, r});
        end
        chk_word("active ri2sw", exp_act[0], act_ri2sw_out);
        chk_word("active sw2ri", exp_act[1], act_sw2ri_out);
        chk_word("active mc2sw", exp_act[2], act_mc2sw_out);
        chk_word("active pool", exp_act[3], act_pool_out);
        chk_word("active up refresh", {30'h0, exp_act[0][21:20]}, {30'h0, act_up_disp_out});
        chk_word("active down refresh", {29'h0, exp_act[1][22:20]}, {29'h0, act_down_disp_out});
    endtask : check_state
    // Counts stay staged until a warm reset copies them across
    task automatic stage_and_apply();
        logic [1:0]  r;
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 4; i++) begin
                axi_write(ofs_tbl[i], wr_tbl[p][i], r);
                chk_word("write answer", {30'h0, RESP_OKAY}, {30'h0, r});
                exp_prog[i] = wr_tbl[p][i] & msk_tbl[i];
            end
            check_state();
            @(posedge mclk_in);
            warm_rst_in <= 1'b1;
            @(posedge mclk_in);
            warm_rst_in <= 1'b0;
            exp_act = exp_prog;
            check_state();
        end
    endtask : stage_and_apply
    // An unmapped word is refused and must leave every register alone
    task automatic unmapped_access();
        logic [31:0] d;
        logic [1:0]  r;
        axi_write(8'h80, 32'hFFFF_FFFF, r);
        chk_word("unmapped write answer", {30'h0, RESP_SLVERR}, {30'h0, r});
        axi_read(8'h80, d, r);
        chk_word("unmapped read answer", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk_word("unmapped read data", 32'h0, d);
        check_state();
        // Only the low byte lane is enabled; upper lanes must keep their staged counts
        s_axi_wstrb_in <= 4'h1;
        axi_write(OFS_RI2SW, 32'hFFFF_FF22, r);
        s_axi_wstrb_in <= 4'hF;
        chk_word("strobe write answer", {30'h0, RESP_OKAY}, {30'h0, r});
        exp_prog[0] = {exp_prog[0][31:8], 8'h22 & msk_tbl[0][7:0]};
        check_state();
    endtask : unmapped_access
    // Headers back to back: {valid, read, isoc, passpw, rsppasspw, coherent, seqid}
    task automatic classify_headers();
        logic [9:0] tbl [10] = '{10'b1_11110_0000, 10'b1_01110_0000, 10'b1_10110_0000, 10'b1_11010_0000,
                                 10'b1_11100_0000, 10'b1_11111_0000, 10'b1_11110_1000, 10'b1_11110_0001,
                                 10'b1_11110_0000, 10'b0_11110_0000};
        logic       e;
        // An edge shows the answer to the header driven two edges earlier
        for (int i = 0; i < 12; i++) begin
            @(posedge mclk_in);
            if (i > 1) begin
                e = &tbl[i-2][9:5] & ~tbl[i-2][4] & (tbl[i-2][3:0] == 4'h0);
                chk_bit("request valid", tbl[i-2][9], req_valid_out);
                chk_bit("high priority", e, high_prio_out);
                chk_bit("refresh path", e, disp_path_out);
            end
            {hdr_valid_in, hdr_read_in, hdr_isoc_in, hdr_passpw_in, hdr_rsppasspw_in, hdr_coherent_in,
             hdr_seqid_in} <= (i < 10) ? tbl[i] : 10'h000;
        end
    endtask : classify_headers
    // ==================================================
    // Clock, watchdog and main sequence
    initial begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end
    initial begin
        repeat (20000) @(posedge mclk_in);
        n_errors++;
        report_and_stop();
    end
    initial begin
        {rst_n_in, warm_rst_in, dual_core_in, s_axi_awvalid_in, s_axi_wvalid_in} = 5'h00;
        {s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = 3'h0;
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 48'h0;
        s_axi_wstrb_in = 4'hF;
        {hdr_valid_in, hdr_read_in, hdr_isoc_in, hdr_passpw_in, hdr_rsppasspw_in, hdr_coherent_in} = 6'h00;
        hdr_seqid_in = 4'h0;
        cold_reset(1'b0);
        check_state();
        stage_and_apply();
        unmapped_access();
        classify_headers();
        cold_reset(1'b1);
        check_state();
        report_and_stop();
    end
endmodule : switch_flow_control_credits_tb
